// File: testbench/cfs_checksum_unit_props.sv
// Purpose: port checks for the checksum unit
// Assumes: one clock, async active-low reset
// Notes:   bound to every instance of the unit
`timescale 1ns/1ns
module cfs_checksum_unit_props
    import cfs_pkg::*;
#(
    parameter int FLASH_AW = 16
)
(
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                flash_req,
    input wire logic [FLASH_AW-1:0] flash_addr,
    input wire logic                cpu_hold,
    input wire logic                fetch_byte_bad
);
    logic                seen_q;
    logic [FLASH_AW-1:0] prev_q;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // -------------------------------
    // scan helpers
    // -------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seen_q <= 1'h0;
            prev_q <= '0;
        end
        else
        begin
            seen_q <= cpu_hold && (seen_q || flash_req);
            prev_q <= flash_req ? flash_addr : prev_q;
        end
    end
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("response not okay");
    a_req_held: assert property (flash_req |-> cpu_hold)
        else $error("flash fetch without cpu hold");
    a_req_single: assert property (flash_req |=> !flash_req)
        else $error("fetch longer than one cycle");
    a_addr_step: assert property (flash_req && seen_q |->
        flash_addr == prev_q + 1'b1)
        else $error("flash address not sequential");
    a_page_start: assert property (flash_req && !seen_q |->
        flash_addr[7:0] == 8'h00)
        else $error("scan start not page aligned");
    a_stall_scan: assert property (!hreadyout && !cpu_hold |=> hreadyout)
        else $error("bus stalled beyond read wait without scan");
    a_hold_runs: assert property ($rose(cpu_hold) |-> cpu_hold[*3])
        else $error("cpu hold dropped early");
    a_init_flag: assert property (hsel && hready && hwrite &&
        htrans == CFS_HTRANS_NONSEQ && haddr[11:0] == CFS_OFF_CONTROL
        ##1 hwdata[CFS_CTL_INIT] |=> ##[0:1] fetch_byte_bad)
        else $error("fetch byte flag missing after init");
endmodule : cfs_checksum_unit_props
bind cfs_checksum_unit cfs_checksum_unit_props #(.FLASH_AW(FLASH_AW)) u_props
    (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
     .hreadyout, .hresp, .flash_req, .flash_addr, .cpu_hold, .fetch_byte_bad);

// File: testbench/cfs_flash_model.sv
// Purpose: flash read port model answering scan fetches
// Assumes: lat_cycles fixed during a scan
// Notes:   idle data toggles so stale bytes never look valid
`timescale 1ns/1ns
module cfs_flash_model
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        flash_req,
    input  wire logic [15:0] flash_addr,
    input  wire logic [3:0]  lat_cycles,
    output logic             flash_valid,
    output logic      [7:0]  flash_data
);
    logic [15:0] addr_q;
    logic [3:0]  wait_q;
    logic        pend_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_q      <= 1'h0;
            flash_valid <= 1'h0;
            flash_data  <= 8'hA5;
        end
        else
        begin
            flash_valid <= 1'h0;
            flash_data  <= ~flash_data;
            if (flash_req && lat_cycles == 4'h0)
            begin
                flash_valid <= 1'h1;
                flash_data  <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5A;
            end
            else if (flash_req)
            begin
                pend_q <= 1'h1;
                addr_q <= flash_addr;
                wait_q <= lat_cycles - 4'h1;
            end
            else if (pend_q && wait_q == 4'h0)
            begin
                pend_q      <= 1'h0;
                flash_valid <= 1'h1;
                flash_data  <= addr_q[7:0] ^ addr_q[15:8] ^ 8'h5A;
            end
            else if (pend_q)
                wait_q <= wait_q - 4'h1;
        end
    end
endmodule : cfs_flash_model

// File: testbench/tb_crc_engine_with_flash_scan.sv
// Purpose: self-checking bench for the checksum unit
// Assumes: read data stands at the edge that ends its data phase
// Notes:   flash bytes are addr low ^ addr high ^ 0x5a
`timescale 1ns/1ns
module tb_crc_engine_with_flash_scan;
    import cfs_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        flash_req, flash_valid, cpu_hold, fetch_byte_bad;
    wire logic   hready = hreadyout;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  lat;
    logic [7:0]  flash_data;
    logic [15:0] flash_addr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    cfs_checksum_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .flash_req, .flash_addr, .flash_data, .flash_valid, .cpu_hold,
        .fetch_byte_bad);
    cfs_flash_model u_flash (.hclk, .hresetn, .flash_req, .flash_addr,
        .lat_cycles(lat), .flash_valid, .flash_data);
    initial
    begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, s, e);
        end
    endtask : check
    // waits on hready with no fixed latency; the timeout ends a hang
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= CFS_HTRANS_NONSEQ;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'h1)
            @(posedge hclk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'h1)
            @(posedge hclk);
        rd = hrdata;
    endtask : bus
    function automatic logic [31:0] upd(input logic w, input logic [31:0] c,
                                        input logic [7:0] b);
        c = w ? c ^ {16'h0, b, 8'h0} : c ^ {24'h0, b};
        for (int i = 0; i < 8; i++)
            if (w)
                c = {16'h0, c[14:0], 1'h0} ^ (c[15] ? 32'(CFS_POLY16) : 0);
            else
                c = (c >> 1) ^ (c[0] ? CFS_POLY32_REFL : 0);
        return c;
    endfunction : upd
    // -------------------------------
    // scenarios
    // -------------------------------
    task automatic t_read(input logic w, input logic [31:0] c, input int k);
        bus(1'h1, CFS_OFF_CONTROL, {27'h0, w, 4'h0});
        for (int p = 0; p < k; p++)
        begin
            bus(1'h0, CFS_OFF_RESULT, 32'h0);
            check(rd[7:0], c[8 * (w ? p % 2 : p % 4) +: 8]);
        end
    endtask : t_read
    task automatic t_stream(input logic w, input logic s);
        logic [31:0] c;
        c = s ? CFS_SEED_ONES : CFS_SEED_ZERO;
        bus(1'h1, CFS_OFF_CONTROL, {27'h0, w, 1'h1, s, 2'h3});
        for (int i = 0; i < 3; i++)
        begin
            bus(1'h1, CFS_OFF_INPUT, 32'(8'hAA + 8'h11 * i));
            c = upd(w, c, 8'(8'hAA + 8'h11 * i));
        end
        if (!w && s)
            check(c, 32'h41B2_07B3);
        t_read(w, c, 5);
        $display("stream test done width16=%0d ones=%0d", w, s);
    endtask : t_stream
    task automatic t_misc();
        logic [7:0] b, e;
        for (int i = 0; i < 8; i++)
        begin
            b = (8'h01 << i) ^ 8'hC0;
            for (int k = 0; k < 8; k++)
                e[k] = b[7 - k];
            bus(1'h1, CFS_OFF_REVERSE, {24'h0, b});
            bus(1'h0, CFS_OFF_REVERSE, 32'h0);
            check(rd[7:0], e);
        end
        bus(1'h1, 12'h01C, 32'hFFFF_FFFF);
        bus(1'h0, 12'h01C, 32'h0);
        check(rd, 32'h0);
        $display("reverse and unmapped test done");
    endtask : t_misc
    task automatic t_scan(input logic [5:0] pg, input int n, input int l);
        logic [31:0] c;
        logic [15:0] a;
        c   = CFS_SEED_ONES;
        lat <= 4'(l);
        bus(1'h1, CFS_OFF_CONTROL, 32'h0000_000C);
        bus(1'h1, CFS_OFF_AUTO, {24'h0, 2'h2, pg});
        bus(1'h1, CFS_OFF_COUNT, 32'(n));
        bus(1'h1, CFS_OFF_CONTROL, 32'h0);
        repeat (2) @(posedge hclk);
        check(cpu_hold, 1'h1);
        bus(1'h1, CFS_OFF_REVERSE, 32'h0000_00AA);
        for (int i = 0; i < 1024 * n; i++)
        begin
            a = 16'(pg * 256 + i);
            c = upd(1'h0, c, a[7:0] ^ a[15:8] ^ 8'h5A);
        end
        bus(1'h1, CFS_OFF_AUTO, 32'h0);
        t_read(1'h0, c, 4);
        $display("scan test done blocks=%0d", n);
    endtask : t_scan
    initial
    begin
        hresetn = 1'h0;
        hsel    = 1'h0;
        htrans  = 2'h0;
        hwrite  = 1'h0;
        hsize   = CFS_HSIZE_WORD;
        haddr   = 32'h0;
        hwdata  = 32'h0;
        lat     = 4'h1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        for (int k = 0; k < 4; k++)
            t_stream(k[1], k[0]);
        t_misc();
        t_scan(6'h03, 1, 2);
        t_scan(6'h0A, 2, 0);
        close_out();
    end
endmodule : tb_crc_engine_with_flash_scan

// File: verilog/cfs_bit_reverse.sv
// Purpose: byte bit-order reversal
// Assumes: registered in the caller
// Notes:   purely combinational
`timescale 1ns/1ns
module cfs_bit_reverse
(
    input  wire logic [7:0] din,
    output logic      [7:0] dout
);
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            dout[i] = din[7 - i];
    end
endmodule : cfs_bit_reverse

// File: verilog/cfs_checksum_unit.sv
// Purpose: checksum unit with register access and automatic flash scan
// Assumes: one clock hclk, flash read port answers with flash_valid
// Notes:   cpu_hold stays high while a scan runs; the bus also stalls
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - 16-bit mode uses generator 0x1021 giving 16-bit result.
// - 32-bit mode uses generator 0x04C11DB7 giving 32-bit result.
// - result seeds to all zeros or all ones across full width.
// - 16-bit mode xors each byte into upper eight result bits.
// - 16-bit: eight left shifts, xor polynomial if top bit set.
// - 32-bit mode xors each byte into lowest result byte.
// - 32-bit: eight right shifts, xor 0xEDB88320 if bottom bit set.
// - each input byte write folds into the result at once.
// - software zeroes pointer; each result read advances it.
// - engine checksums consecutive 1024-byte flash blocks unaided.
// - with auto enable, any control write starts the scan.
// - cpu is held until the scan finishes.
// - third fetched byte after start write is indeterminate.
// - bit-reverse register reverses the written byte's bits.
// - reversed byte readable by the very next access.
// - dummy reverse write after start has no other effect.
// - poly select zero means 32-bit, one means 16-bit.
// - seed select one loads ones, zero loads zeros.
// - pointer picks result byte; 16-bit mode repeats low bytes.
// - result may be invalid one cycle after init.
module cfs_checksum_unit
    import cfs_pkg::*;
#(
    parameter int FLASH_AW = 16
)
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic                     flash_req,
    output logic      [FLASH_AW-1:0] flash_addr,
    input  wire logic [7:0]          flash_data,
    input  wire logic                flash_valid,
    output logic                     cpu_hold,
    output logic                     fetch_byte_bad
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    logic [31:0]         result_q, result_d;
    logic [1:0]          pnt_q, pnt_d;
    logic                poly_width_select_q, poly_width_select_d;
    logic                seedsel_q, seedsel_d;
    logic                auto_en_q, auto_en_d;
    logic [5:0]          start_q, start_d;
    logic [7:0]          count_q, count_d;
    logic [7:0]          input_q, input_d;
    logic [7:0]          rev_q, rev_d;
    logic                init_q, init_d;
    cfs_scan_state_t     st_q, st_d;
    logic [FLASH_AW-1:0] faddr_q, faddr_d;
    logic [CFS_BLOCK_SHIFT-1:0] bytecnt_q, bytecnt_d;
    logic [7:0]          blocks_q, blocks_d;
    logic [1:0]          fetch_cnt_q, fetch_cnt_d;
    logic                ph_act_q, ph_act_d;
    logic                ph_wr_q, ph_wr_d;
    logic [11:0]         ph_addr_q, ph_addr_d;
    logic [31:0]         rdata_q, rdata_d;
    logic                rd_done_q, rd_done_d;

    logic [7:0]  step_byte;
    logic [31:0] step_out;
    logic [7:0]  rev_out;
    logic        scan_busy;
    logic [7:0]  sel_byte;

    cfs_crc_step u_step
    (
        .wide16  (poly_width_select_q),
        .acc_in  (result_q),
        .data_in (step_byte),
        .acc_out (step_out)
    );

    cfs_bit_reverse u_rev
    (
        .din  (hwdata[7:0]),
        .dout (rev_out)
    );

    function automatic logic [7:0] pick_byte
    (
        input logic [31:0] r,
        input logic [1:0]  p,
        input logic        w16
    );
        logic [1:0] idx;
        idx = w16 ? {1'b0, p[0]} : p;
        pick_byte = r[idx*8 +: 8];
    endfunction : pick_byte

    assign scan_busy = (st_q != CFS_IDLE);
    assign sel_byte  = pick_byte(result_q, pnt_q, poly_width_select_q);
    assign step_byte = scan_busy ? flash_data : hwdata[7:0];

    //------------------------------------------------------------
    // bus outputs
    //------------------------------------------------------------
    // data phase stalls during a scan, holding the cpu too;
    // reads take one wait state so hrdata stands from a flop
    assign hreadyout = !(ph_act_q &&
                         (scan_busy || (!ph_wr_q && !rd_done_q)));
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign cpu_hold  = scan_busy;
    assign flash_req = (st_q == CFS_FETCH);
    assign flash_addr = faddr_q;
    assign fetch_byte_bad = (fetch_cnt_q != 2'd0);

    //------------------------------------------------------------
    // next-state logic
    //------------------------------------------------------------
    always_comb
    begin
        logic wr_go;
        logic rd_go;
        wr_go = 1'b0;
        rd_go = 1'b0;
        result_d  = result_q;
        pnt_d     = pnt_q;
        poly_width_select_d = poly_width_select_q;
        seedsel_d = seedsel_q;
        auto_en_d = auto_en_q;
        start_d   = start_q;
        count_d   = count_q;
        input_d   = input_q;
        rev_d     = rev_q;
        init_d    = 1'b0;
        st_d      = st_q;
        faddr_d   = faddr_q;
        bytecnt_d = bytecnt_q;
        blocks_d  = blocks_q;
        fetch_cnt_d = (fetch_cnt_q != 2'd0) ?
                      fetch_cnt_q - 2'd1 : 2'd0;
        ph_act_d  = ph_act_q;
        ph_wr_d   = ph_wr_q;
        ph_addr_d = ph_addr_q;
        rdata_d   = rdata_q;

        rd_go     = ph_act_q && !ph_wr_q && !scan_busy && !rd_done_q;
        rd_done_d = rd_go;
        if (hreadyout)
        begin
            wr_go = ph_act_q && ph_wr_q;
            ph_act_d  = hsel && hready && (htrans == CFS_HTRANS_NONSEQ);
            ph_wr_d   = hwrite;
            ph_addr_d = haddr[11:0];
        end

        // address decode; unmapped reads give zero, writes ignored
        if (rd_go)
        begin
            rdata_d = 32'h0000_0000;
            if (ph_addr_q == CFS_OFF_CONTROL)
                rdata_d = {27'h000_0000, poly_width_select_q, 1'b0,
                           seedsel_q, pnt_q};
            else if (ph_addr_q == CFS_OFF_INPUT)
                rdata_d = {24'h00_0000, input_q};
            else if (ph_addr_q == CFS_OFF_RESULT)
            begin
                rdata_d = {24'h00_0000, sel_byte};
                pnt_d   = pnt_q + 2'd1;
            end
            else if (ph_addr_q == CFS_OFF_AUTO)
                rdata_d = {24'h00_0000, auto_en_q, 1'b0, start_q};
            else if (ph_addr_q == CFS_OFF_COUNT)
                rdata_d = {24'h00_0000, count_q};
            else if (ph_addr_q == CFS_OFF_REVERSE)
                rdata_d = {24'h00_0000, rev_q};
            else if (ph_addr_q == CFS_OFF_STATUS)
                rdata_d = {31'h0000_0000, scan_busy};
        end

        if (wr_go)
        begin
            if (ph_addr_q == CFS_OFF_CONTROL)
            begin
                poly_width_select_d = hwdata[CFS_CTL_POLY_WIDTH_SELECT];
                seedsel_d = hwdata[CFS_CTL_SEEDSEL];
                pnt_d     = hwdata[CFS_CTL_PNT_HI:CFS_CTL_PNT_LO];
                if (hwdata[CFS_CTL_INIT])
                begin
                    // seed follows the select bit written together
                    result_d = hwdata[CFS_CTL_SEEDSEL] ?
                               CFS_SEED_ONES : CFS_SEED_ZERO;
                    init_d   = 1'b1;
                end
                if (hwdata[CFS_CTL_INIT] || auto_en_q)
                    fetch_cnt_d = 2'd3;
                if (auto_en_q && st_q == CFS_IDLE)
                begin
                    st_d      = CFS_FETCH;
                    faddr_d   = FLASH_AW'({start_q, 8'h00});
                    bytecnt_d = '0;
                    blocks_d  = count_q;
                end
            end
            else if (ph_addr_q == CFS_OFF_INPUT)
            begin
                input_d  = hwdata[7:0];
                result_d = step_out;
            end
            else if (ph_addr_q == CFS_OFF_RESULT)
            begin
                // a result write replaces the pointed byte
                result_d[pnt_q*8 +: 8] = hwdata[7:0];
                pnt_d = pnt_q + 2'd1;
            end
            else if (ph_addr_q == CFS_OFF_AUTO)
            begin
                auto_en_d = hwdata[CFS_AUTO_EN];
                start_d   = hwdata[CFS_AUTO_ST_HI:0];
            end
            else if (ph_addr_q == CFS_OFF_COUNT)
                count_d = hwdata[7:0];
            else if (ph_addr_q == CFS_OFF_REVERSE)
                rev_d = rev_out;
        end

        //--------------------------------------------------------
        // flash scan
        //--------------------------------------------------------
        case (st_q)
            CFS_IDLE:
                ;
            CFS_FETCH:
                st_d = CFS_WAIT;
            CFS_WAIT:
            begin
                if (flash_valid)
                begin
                    result_d  = step_out;
                    faddr_d   = faddr_q + FLASH_AW'(1);
                    bytecnt_d = bytecnt_q + 1'b1;
                    st_d      = CFS_FETCH;
                    if (&bytecnt_q)
                    begin
                        blocks_d = blocks_q - 8'd1;
                        if (blocks_q <= 8'd1)
                            st_d = CFS_DONE;
                    end
                end
            end
            CFS_DONE:
                st_d = CFS_IDLE;
            default:
                st_d = CFS_IDLE;
        endcase
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result_q  <= CFS_SEED_ZERO;
            pnt_q     <= 2'd0;
            poly_width_select_q <= 1'b0;
            seedsel_q <= 1'b0;
            auto_en_q <= 1'b0;
            start_q   <= 6'h00;
            count_q   <= 8'h00;
            input_q   <= 8'h00;
            rev_q     <= 8'h00;
            init_q    <= 1'b0;
            st_q      <= CFS_IDLE;
            faddr_q   <= '0;
            bytecnt_q <= '0;
            blocks_q  <= 8'h00;
            fetch_cnt_q <= 2'd0;
            ph_act_q  <= 1'b0;
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 12'h000;
            rdata_q   <= 32'h0000_0000;
            rd_done_q <= 1'b0;
        end
        else
        begin
            result_q  <= result_d;
            pnt_q     <= pnt_d;
            poly_width_select_q <= poly_width_select_d;
            seedsel_q <= seedsel_d;
            auto_en_q <= auto_en_d;
            start_q   <= start_d;
            count_q   <= count_d;
            input_q   <= input_d;
            rev_q     <= rev_d;
            init_q    <= init_d;
            st_q      <= st_d;
            faddr_q   <= faddr_d;
            bytecnt_q <= bytecnt_d;
            blocks_q  <= blocks_d;
            fetch_cnt_q <= fetch_cnt_d;
            ph_act_q  <= ph_act_d;
            ph_wr_q   <= ph_wr_d;
            ph_addr_q <= ph_addr_d;
            rdata_q   <= rdata_d;
            rd_done_q <= rd_done_d;
        end
    end
endmodule : cfs_checksum_unit

// File: verilog/cfs_crc_step.sv
// Purpose: combinational one-byte checksum update
// Assumes: wide selects 16-bit mode when high
// Notes:   unrolled over eight bit steps
`timescale 1ns/1ns
module cfs_crc_step
    import cfs_pkg::*;
(
    input  wire logic        wide16,
    input  wire logic [31:0] acc_in,
    input  wire logic [7:0]  data_in,
    output logic      [31:0] acc_out
);
    logic [15:0] a16;
    logic [31:0] a32;
    always_comb
    begin
        a16 = acc_in[15:0] ^ {data_in, 8'h00};
        a32 = acc_in ^ {24'h00_0000, data_in};
        for (int i = 0; i < 8; i++)
        begin
            if (a16[15])
                a16 = {a16[14:0], 1'b0} ^ CFS_POLY16;
            else
                a16 = {a16[14:0], 1'b0};
            if (a32[0])
                a32 = {1'b0, a32[31:1]} ^ CFS_POLY32_REFL;
            else
                a32 = {1'b0, a32[31:1]};
        end
        acc_out = wide16 ? {16'h0000, a16} : a32;
    end
endmodule : cfs_crc_step

// File: verilog/cfs_pkg.sv
// Purpose: shared constants for the checksum unit with flash scan
// Assumes: AHB-Lite register access, 32-bit words, byte-wide fields
// Notes:   offsets are byte addresses of aligned words
package cfs_pkg;
    localparam logic [11:0] CFS_OFF_CONTROL = 12'h000;
    localparam logic [11:0] CFS_OFF_INPUT   = 12'h004;
    localparam logic [11:0] CFS_OFF_RESULT  = 12'h008;
    localparam logic [11:0] CFS_OFF_AUTO    = 12'h00C;
    localparam logic [11:0] CFS_OFF_COUNT   = 12'h010;
    localparam logic [11:0] CFS_OFF_REVERSE = 12'h014;
    localparam logic [11:0] CFS_OFF_STATUS  = 12'h018;
    localparam int CFS_CTL_PNT_LO   = 0;
    localparam int CFS_CTL_PNT_HI   = 1;
    localparam int CFS_CTL_SEEDSEL  = 2;
    localparam int CFS_CTL_INIT     = 3;
    localparam int CFS_CTL_POLY_WIDTH_SELECT  = 4;
    localparam int CFS_AUTO_EN      = 7;
    localparam int CFS_AUTO_ST_HI   = 5;
    localparam logic [15:0] CFS_POLY16 = 16'h1021;
    localparam logic [31:0] CFS_POLY32 = 32'h04C1_1DB7;
    localparam logic [31:0] CFS_POLY32_REFL = 32'hEDB8_8320;
    localparam logic [31:0] CFS_SEED_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] CFS_SEED_ZERO = 32'h0000_0000;
    localparam int CFS_BLOCK_BYTES  = 1024;
    localparam int CFS_BLOCK_SHIFT  = 10;
    localparam logic [1:0] CFS_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] CFS_HSIZE_WORD    = 2'b10;
    typedef enum logic [1:0]
    {
        CFS_IDLE  = 2'b00,
        CFS_FETCH = 2'b01,
        CFS_WAIT  = 2'b10,
        CFS_DONE  = 2'b11
    } cfs_scan_state_t;
endpackage : cfs_pkg
